// ### hdl/dcg_pkg.sv
package dcg_pkg;
	// Input clock edges per half period of the word frame clock
	localparam logic [2:0] FRAME_HALF_DUAL   = 3'h4; // divide by 4, both edges counted
	localparam logic [2:0] FRAME_HALF_SINGLE = 3'h0; // divide by 8 wraps the 3-bit count
	localparam logic [2:0] EDGE_COUNT_RESET  = 3'h0;
	localparam logic       FRAME_RESET       = 1'b0;
	localparam logic       RUN_RESET         = 1'b0;
	localparam int         SYNC_STAGES       = 2;
endpackage

// ### hdl/dcg_clock_gate.sv
`timescale 1ns/10ps
`default_nettype none

module dcg_clock_gate (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic inputClock,
	input  wire logic clockHold,
	input  wire logic edgeModeSelect,
	input  wire logic masterReset,
	output var  logic internalRun,
	output var  logic gatedClock,
	output var  logic sampleStrobe,
	output var  logic wordFrameClockP,
	output var  logic wordFrameClockN
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [1:0] inClkSync;
	logic [1:0] holdSync;
	logic [1:0] modeSync;
	logic [1:0] mrSync;
	logic       inClkLast;

	always_ff @(posedge clk) begin
		if (reset) begin
			inClkSync <= 2'h0;
			holdSync  <= 2'h0;
			modeSync  <= 2'h0;
			mrSync    <= 2'h0;
			inClkLast <= 1'b0;
		end else begin
			inClkSync <= {inClkSync[0], inputClock};
			holdSync  <= {holdSync[0], clockHold};
			modeSync  <= {modeSync[0], edgeModeSelect};
			mrSync    <= {mrSync[0], masterReset};
			inClkLast <= inClkSync[1];
		end
	end

	logic inClk;
	logic holdIn;
	logic dualEdge;
	logic mrIn;
	logic riseEdge;
	logic fallEdge;
	assign inClk    = inClkSync[1];
	assign holdIn   = holdSync[1];
	assign dualEdge = !modeSync[1];
	assign mrIn     = mrSync[1];
	assign riseEdge = inClk && !inClkLast;
	assign fallEdge = !inClk && inClkLast;

	////////////////////////////////////////////////////////////////////////////
	// Run enable: changes only at an input clock falling edge, except master reset clears it at any time
	always_ff @(posedge clk) begin
		if (reset) begin
			internalRun <= dcg_pkg::RUN_RESET;
		end else if (mrIn) begin
			internalRun <= 1'b0;
		end else if (fallEdge) begin
			internalRun <= !holdIn;
		end
	end

	// Gated clock follows the input clock only while running
	always_ff @(posedge clk) begin
		if (reset) begin
			gatedClock <= 1'b0;
		end else begin
			gatedClock <= inClk && internalRun && !mrIn;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial sample strobe
	logic activeEdge;
	assign activeEdge = internalRun && !mrIn && (riseEdge || (dualEdge && fallEdge));

	always_ff @(posedge clk) begin
		if (reset) begin
			sampleStrobe <= 1'b0;
		end else begin
			sampleStrobe <= activeEdge;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Word frame divider, counting input clock edges
	logic [2:0] edgeCount;
	logic [2:0] next_edgeCount;
	logic       frameAdvance;
	assign frameAdvance   = internalRun && !mrIn && (riseEdge || fallEdge);
	assign next_edgeCount = edgeCount + 3'h1;

	// True when the counted edge closes a half period of the frame clock
	// Greater-or-equal lets a mid-frame switch to dual mode wrap at once
	function automatic logic frameWrap(input logic [2:0] nextCount, input logic dual);
		if (dual) begin
			return nextCount >= dcg_pkg::FRAME_HALF_DUAL;
		end else begin
			return nextCount == dcg_pkg::FRAME_HALF_SINGLE;
		end
	endfunction

	always_ff @(posedge clk) begin
		if (reset) begin
			edgeCount       <= dcg_pkg::EDGE_COUNT_RESET;
			wordFrameClockP <= dcg_pkg::FRAME_RESET;
			wordFrameClockN <= !dcg_pkg::FRAME_RESET;
		end else if (frameAdvance) begin
			if (frameWrap(next_edgeCount, dualEdge)) begin
				edgeCount       <= dcg_pkg::EDGE_COUNT_RESET;
				wordFrameClockP <= !wordFrameClockP;
				wordFrameClockN <= wordFrameClockP;
			end else begin
				edgeCount <= next_edgeCount;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_holdStops;
		@(posedge clk) disable iff (reset) fallEdge && holdIn |=> !internalRun;
	endproperty
	a_holdStops: assert property (p_holdStops) else $error("hold did not stop run");

	property p_onlyAtFall;
		@(posedge clk) disable iff (reset)
			$rose(internalRun) |-> $past(fallEdge) && !$past(holdIn);
	endproperty
	a_onlyAtFall: assert property (p_onlyAtFall) else $error("run rose off a falling edge");

	property p_resume;
		@(posedge clk) disable iff (reset) fallEdge && !holdIn && !mrIn |=> internalRun;
	endproperty
	a_resume: assert property (p_resume) else $error("run not resumed");

	property p_firstBit;
		@(posedge clk) disable iff (reset)
			riseEdge && internalRun && !mrIn |=> sampleStrobe;
	endproperty
	a_firstBit: assert property (p_firstBit) else $error("rising edge not sampled");

	property p_singleEdge;
		@(posedge clk) disable iff (reset) fallEdge && !dualEdge |=> !sampleStrobe;
	endproperty
	a_singleEdge: assert property (p_singleEdge) else $error("falling edge sampled");

	property p_frozen;
		@(posedge clk) disable iff (reset)
			!internalRun |=> $stable(wordFrameClockP) && !sampleStrobe;
	endproperty
	a_frozen: assert property (p_frozen) else $error("activity while held");

	property p_masterReset;
		@(posedge clk) disable iff (reset) mrIn |=> !internalRun && !gatedClock;
	endproperty
	a_masterReset: assert property (p_masterReset) else $error("master reset ignored");

	property p_frameDiff;
		@(posedge clk) disable iff (reset) wordFrameClockN == !wordFrameClockP;
	endproperty
	a_frameDiff: assert property (p_frameDiff) else $error("frame pair not complementary");

	property p_frameOnEdge;
		@(posedge clk) disable iff (reset)
			$changed(wordFrameClockP) |-> $past(frameAdvance) && $past(edgeCount) != 3'h0;
	endproperty
	a_frameOnEdge: assert property (p_frameOnEdge) else $error("frame toggled off phase");

	property p_dualHalf;
		@(posedge clk) disable iff (reset)
			frameAdvance && dualEdge && edgeCount == 3'h3 |=> $changed(wordFrameClockP);
	endproperty
	a_dualHalf: assert property (p_dualHalf) else $error("divide by 4 missed");

	property p_singleHalf;
		@(posedge clk) disable iff (reset)
			frameAdvance && !dualEdge && edgeCount == 3'h7 |=> $changed(wordFrameClockP);
	endproperty
	a_singleHalf: assert property (p_singleHalf) else $error("divide by 8 missed");

	property p_gateRise;
		@(posedge clk) disable iff (reset)
			$rose(gatedClock) |-> $past(internalRun) && $past(inClk);
	endproperty
	a_gateRise: assert property (p_gateRise) else $error("gated rise while held");

	property p_noRunt;
		@(posedge clk) disable iff (reset)
			$fell(gatedClock) |-> !$past(inClk) || $past(mrIn);
	endproperty
	a_noRunt: assert property (p_noRunt) else $error("runt gated clock pulse");

	property p_runSteady;
		@(posedge clk) disable iff (reset) !fallEdge && !mrIn |=> $stable(internalRun);
	endproperty
	a_runSteady: assert property (p_runSteady) else $error("run moved early");

	property p_countFrozen;
		@(posedge clk) disable iff (reset) !frameAdvance |=> $stable(edgeCount);
	endproperty
	a_countFrozen: assert property (p_countFrozen) else $error("divider moved");

	property p_frameStill;
		@(posedge clk) disable iff (reset) !frameAdvance |=> $stable(wordFrameClockP);
	endproperty
	a_frameStill: assert property (p_frameStill) else $error("frame moved");

	property p_dualFall;
		@(posedge clk) disable iff (reset)
			fallEdge && dualEdge && internalRun && !mrIn |=> sampleStrobe;
	endproperty
	a_dualFall: assert property (p_dualFall) else $error("falling edge not sampled");

endmodule

`default_nettype wire

// ### verif/dcg_source_model.sv
`timescale 1ns/10ps
`default_nettype none

// Free running device input clock; HALF sets the half period in clk cycles
module dcg_source_model #(
	parameter int HALF = 4
) (
	input  wire logic clk,
	output var  logic inputClock
);
	int cnt = 0;

	initial inputClock = 1'b0;

	always @(negedge clk) begin
		cnt = (cnt + 1) % HALF;
		if (cnt == 0) inputClock <= ~inputClock;
	end
endmodule

`default_nettype wire

// ### verif/dcg_clock_gate_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module dcg_clock_gate_tb_top;
	logic clk = 1'b0, reset = 1'b1, clockHold = 1'b0, edgeModeSelect = 1'b0, masterReset = 1'b0;
	logic inputClock, internalRun, gatedClock, sampleStrobe, wordFrameClockP, wordFrameClockN;
	int   numErrors = 0, testsRun = 0, icCount = 0, sc = 0, cycles = 0, gc = 0;

	always #4 clk = ~clk;

	dcg_source_model #(.HALF(4)) dcg_source_model_inst (.clk(clk), .inputClock(inputClock));

	dcg_clock_gate dcg_clock_gate_inst (.clk(clk), .reset(reset), .inputClock(inputClock),
		.clockHold(clockHold), .edgeModeSelect(edgeModeSelect), .masterReset(masterReset),
		.internalRun(internalRun), .gatedClock(gatedClock), .sampleStrobe(sampleStrobe),
		.wordFrameClockP(wordFrameClockP), .wordFrameClockN(wordFrameClockN));

	always @(negedge inputClock) icCount++;
	always @(posedge gatedClock) gc++;
	always @(posedge clk) begin
		if (sampleStrobe === 1'b1) sc <= sc + 1;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			numErrors++;
			printVerdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			numErrors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic settle();
		repeat (2) @(negedge inputClock);
		repeat (4) @(negedge clk);
	endtask

	task automatic t_frame(input logic m, input logic [31:0] exp);
		int t0, s0, g0;
		@(negedge clk) edgeModeSelect = m;
		repeat (2) @(posedge wordFrameClockP);
		@(negedge clk);
		t0 = icCount;
		s0 = sc;
		g0 = gc;
		@(posedge wordFrameClockP);
		@(negedge clk);
		check(32'(icCount - t0), exp);
		check(32'(sc - s0), 32'h8);
		check(32'(gc - g0), exp);
		check({31'h0, wordFrameClockP}, 32'h1);
		check({31'h0, wordFrameClockN}, {31'h0, ~wordFrameClockP});
	endtask

	task automatic t_hold();
		int s0, g0;
		logic p;
		@(posedge inputClock);
		@(negedge clk) clockHold = 1'b1;
		repeat (2) @(negedge clk);
		check({31'h0, internalRun}, 32'h1);
		settle();
		check({31'h0, internalRun}, 32'h0);
		check({31'h0, gatedClock}, 32'h0);
		p = wordFrameClockP;
		s0 = sc;
		g0 = gc;
		repeat (8) @(negedge inputClock);
		check(32'(sc - s0), 32'h0);
		check(32'(gc - g0), 32'h0);
		check({31'h0, wordFrameClockP}, {31'h0, p});
		@(negedge clk) clockHold = 1'b0;
		settle();
		check({31'h0, internalRun}, 32'h1);
		s0 = sc;
		@(negedge inputClock);
		check(32'(sc > s0), 32'h1);
	endtask

	task automatic t_mreset();
		@(negedge clk) masterReset = 1'b1;
		repeat (6) @(negedge clk);
		check({31'h0, internalRun}, 32'h0);
		check({31'h0, gatedClock}, 32'h0);
		masterReset = 1'b0;
		settle();
		check({31'h0, internalRun}, 32'h1);
	endtask

	task automatic printVerdict();
		$display("errors=%0d checks=%0d", numErrors, testsRun);
		if (numErrors == 0 && testsRun > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (16) @(negedge clk);
		reset = 1'b0;
		settle();
		check({31'h0, internalRun}, 32'h1);
		t_frame(1'b0, 32'h4);
		t_frame(1'b1, 32'h8);
		t_hold();
		t_mreset();
		printVerdict();
	end
endmodule

`default_nettype wire
